// ===== src/scrc_consts.svh
// constants for the system clock ratio configuration block
//
// Operation
// - pll ratio codes 2..5 give csb ratio
// - lbc clock is one or two csb
// - local bus clock is lbc over 2/4/8
// - memory data moves on both clock edges
// - ratios come from reset config word low
`ifndef SCRC_CONSTS_SVH
`define SCRC_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define SCRC_OFF_STATUS      4'h0
`define SCRC_OFF_LBCTRL      4'h4
`define SCRC_OFF_RATIO       4'h8

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SCRC_ST_LOCAL_BUS_CLOCK_MODE_BIT     4
`define SCRC_ST_MEMCM_BIT    5
`define SCRC_ST_RSVD_BIT     6
`define SCRC_ST_DONE_BIT     7
`define SCRC_RT_LOCAL_BUS_CLOCK_MODE_LSB     4
`define SCRC_RT_DIV_LSB      8

// ---------------------------------------------------------------
// pll ratio codes, reset values and the memory clock half period
// ---------------------------------------------------------------
`define SCRC_PLL_2TO1        4'h2
`define SCRC_PLL_3TO1        4'h3
`define SCRC_PLL_4TO1        4'h4
`define SCRC_PLL_5TO1        4'h5
`define SCRC_LBDIV_RST       2'h2
`define SCRC_MEM_HALF        4'h1

`endif

// ===== src/scrc_pkg.sv
// types for the system clock ratio configuration block
package scrc_pkg;

   // local bus divider field encodings
   typedef enum logic [1:0] {
      SCRC_DIV2 = 2'h0,
      SCRC_DIV4 = 2'h1,
      SCRC_DIV8 = 2'h2,
      SCRC_DIVX = 2'h3
   } scrc_lbdiv_t;

endpackage : scrc_pkg

// ===== src/scrc_clk_div.sv
// toggle divider making a clock-like output from a half-period count
`timescale 1ns/10ps
module scrc_clk_div #(
   parameter int W = 4                  // width of the half-period count
) (
   input  wire logic         clock,     // block clock
   input  wire logic         rst,       // async reset, active high
   input  wire logic         clk_en,    // freezes state while low
   input  wire logic         run,       // enables toggling
   input  wire logic [W-1:0] half_cnt,  // cycles per half period, not zero
   output logic              clk_out    // divided clock, from a flop
);

   logic [W-1:0] cnt_ff;                // cycles spent in this half
   logic         out_ff;                // output level

   // ---------------------------------------------------------------
   // counter and toggle
   // ---------------------------------------------------------------
   // a new half_cnt is compared on every cycle, so a live change can end
   // the current half early, as a runt shorter than the old half period
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
         out_ff <= 1'b0;
      end else if (clk_en) begin
         if (!run) begin
            cnt_ff <= '0;
            out_ff <= 1'b0;
         end else if (cnt_ff >= half_cnt - W'(1)) begin
            cnt_ff <= '0;
            out_ff <= ~out_ff;
         end else begin
            cnt_ff <= cnt_ff + W'(1);
         end
      end
   end

   assign clk_out = out_ff;

endmodule : scrc_clk_div

// ===== src/scrc_top.sv
// clock ratio configuration: strap capture, ratio decode, clock dividers
`timescale 1ns/10ps
`include "scrc_consts.svh"
module scrc_top (
   input  wire logic        clock,                 // 100 MHz block clock
   input  wire logic        rst,                   // power-on reset, async high
   input  wire logic        clk_en,                // freezes all state when low
   input  wire logic [3:0]  pll_ratio_field,       // strap, ratio code
   input  wire logic        local_bus_clock_mode,  // strap, 1 = lbc at 2x csb
   input  wire logic        memory_clock_mode,     // strap, memory clock mode
   input  wire logic [3:0]  address,               // avalon byte address
   input  wire logic        read,                  // avalon read
   input  wire logic        write,                 // avalon write
   input  wire logic [31:0] writedata,             // avalon write data
   input  wire logic [3:0]  byteenable,            // avalon byte lanes
   output logic [31:0]      readdata,              // avalon read data
   output logic             waitrequest,           // avalon stall
   output logic [2:0]       csb_ratio,             // csb to input ratio, 0 if bad
   output logic [1:0]       lbc_mult,              // lbc to csb multiple
   output logic [3:0]       lb_divisor,            // lbc to local bus divisor
   output logic             cfg_done,              // straps captured
   output logic             cfg_reserved,          // captured code is reserved
   output logic             local_bus_clock_out,   // external local bus clock
   output logic             memory_clock,          // memory clock
   output logic             mem_beat               // one data beat per edge
);
   import scrc_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [3:0]  pll_ratio_ff;        // captured ratio code
   logic        local_bus_clock_mode_ff;             // captured lbc mode
   logic        memcm_ff;            // captured memory clock mode
   logic        done_ff;             // capture has happened
   logic [2:0]  csb_ratio_ff;        // decoded csb ratio
   logic        rsvd_ff;             // reserved code seen
   logic [1:0]  lbc_mult_ff;         // 1 or 2
   scrc_lbdiv_t lbdiv_ff;            // local bus divider field
   logic [3:0]  lb_divisor_ff;       // 2, 4 or 8
   logic [3:0]  lb_half;             // local bus half period in clocks
   logic        beat_ff;             // memory beat strobe
   logic [31:0] readdata_ff;         // read data register
   logic        waitreq_ff;          // waitrequest register
   logic        req;                 // a request is on the bus
   logic        take;                // request completes this edge

   // ---------------------------------------------------------------
   // strap capture
   // ---------------------------------------------------------------
   // straps are sampled by a clocked process on the first enabled edge
   // after release, never loaded by the reset itself
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pll_ratio_ff <= 4'h0;
         local_bus_clock_mode_ff      <= 1'b0;
         memcm_ff     <= 1'b0;
         done_ff      <= 1'b0;
      end else if (clk_en && !done_ff) begin
         pll_ratio_ff <= pll_ratio_field;
         local_bus_clock_mode_ff      <= local_bus_clock_mode;
         memcm_ff     <= memory_clock_mode;
         done_ff      <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // ratio decode
   // ---------------------------------------------------------------
   // reserved codes give ratio 0 and a flag; nothing stops the
   // clocks, since the code is the configuring party's to get right
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         csb_ratio_ff <= 3'h0;
         rsvd_ff      <= 1'b0;
         lbc_mult_ff  <= 2'h1;
      end else if (clk_en && done_ff) begin
         rsvd_ff     <= 1'b0;
         lbc_mult_ff <= local_bus_clock_mode_ff ? 2'h2 : 2'h1;
         unique case (pll_ratio_ff)
            `SCRC_PLL_2TO1: csb_ratio_ff <= 3'h2;
            `SCRC_PLL_3TO1: csb_ratio_ff <= 3'h3;
            `SCRC_PLL_4TO1: csb_ratio_ff <= 3'h4;
            `SCRC_PLL_5TO1: csb_ratio_ff <= 3'h5;
            default: begin
               // reserved encodings
               csb_ratio_ff <= 3'h0;
               rsvd_ff      <= 1'b1;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // local bus divider select
   // ---------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lb_divisor_ff <= 4'h8;
      end else if (clk_en) begin
         unique case (lbdiv_ff)
            SCRC_DIV2: lb_divisor_ff <= 4'h2;
            SCRC_DIV4: lb_divisor_ff <= 4'h4;
            default:   lb_divisor_ff <= 4'h8;
         endcase
      end
   end

   // the clock input stands for lbc at 2x csb; in 1x mode each half
   // period of the local bus clock doubles
   assign lb_half = local_bus_clock_mode_ff ? {1'b0, lb_divisor_ff[3:1]} : lb_divisor_ff;

   scrc_clk_div #(.W(4)) u_lb_div (
      .clock   (clock),
      .rst     (rst),
      .clk_en  (clk_en),
      .run     (done_ff),
      .half_cnt(lb_half),
      .clk_out (local_bus_clock_out)
   );

   scrc_clk_div #(.W(4)) u_mem_div (
      .clock   (clock),
      .rst     (rst),
      .clk_en  (clk_en),
      .run     (done_ff),
      .half_cnt(`SCRC_MEM_HALF),
      .clk_out (memory_clock)
   );

   // ---------------------------------------------------------------
   // memory beat: one beat on each edge of the memory clock
   // ---------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         beat_ff <= 1'b0;
      end else if (clk_en) begin
         beat_ff <= done_ff;
      end
   end

   // ---------------------------------------------------------------
   // avalon slave
   // ---------------------------------------------------------------
   // one wait cycle per access keeps read data straight from a flop
   assign req  = read | write;
   assign take = req & ~waitreq_ff;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         waitreq_ff <= 1'b1;
      end else if (clk_en) begin
         waitreq_ff <= ~(req & waitreq_ff);
      end
   end

   // local bus control register; reserved code 3 is not stored
   // the write lands only at the edge that completes the access, the
   // same edge at which the master sees waitrequest low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lbdiv_ff <= scrc_lbdiv_t'(`SCRC_LBDIV_RST);
      end else if (clk_en && take && write && byteenable[0] &&
                   address == `SCRC_OFF_LBCTRL &&
                   writedata[1:0] != SCRC_DIVX) begin
         lbdiv_ff <= scrc_lbdiv_t'(writedata[1:0]);
      end
   end

   // read mux loads while the wait cycle runs; unmapped reads zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readdata_ff <= 32'h0;
      end else if (clk_en && read && waitreq_ff) begin
         readdata_ff <= 32'h0;
         unique case (address)
            `SCRC_OFF_STATUS: begin
               readdata_ff[3:0]                <= pll_ratio_ff;
               readdata_ff[`SCRC_ST_LOCAL_BUS_CLOCK_MODE_BIT]  <= local_bus_clock_mode_ff;
               readdata_ff[`SCRC_ST_MEMCM_BIT] <= memcm_ff;
               readdata_ff[`SCRC_ST_RSVD_BIT]  <= rsvd_ff;
               readdata_ff[`SCRC_ST_DONE_BIT]  <= done_ff;
            end
            `SCRC_OFF_LBCTRL: readdata_ff[1:0] <= lbdiv_ff;
            `SCRC_OFF_RATIO: begin
               readdata_ff[2:0]                      <= csb_ratio_ff;
               readdata_ff[`SCRC_RT_LOCAL_BUS_CLOCK_MODE_LSB +: 2]   <= lbc_mult_ff;
               readdata_ff[`SCRC_RT_DIV_LSB +: 4]    <= lb_divisor_ff;
            end
            default: readdata_ff <= 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign readdata     = readdata_ff;
   assign waitrequest  = waitreq_ff;
   assign csb_ratio    = csb_ratio_ff;
   assign lbc_mult     = lbc_mult_ff;
   assign lb_divisor   = lb_divisor_ff;
   assign cfg_done     = done_ff;
   assign cfg_reserved = rsvd_ff;
   assign mem_beat     = beat_ff;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // helper: enabled cycles since the last local bus clock edge
   // a half period in flight when the divisor changes is a runt, so
   // it is skipped; the one after it must already have the new length
   logic [4:0] lb_gap_ff;            // cycles since last detected edge
   logic       lb_prev_ff;           // clock level one edge earlier
   logic [3:0] lb_half_prev_ff;      // half period one edge earlier
   logic       lb_skip_ff;           // half period spans a divisor change
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lb_gap_ff       <= 5'h0;
         lb_prev_ff      <= 1'b0;
         lb_half_prev_ff <= 4'h0;
         lb_skip_ff      <= 1'b1;
      end else if (clk_en) begin
         lb_prev_ff      <= local_bus_clock_out;
         lb_gap_ff       <= (local_bus_clock_out != lb_prev_ff) ? 5'h1 : lb_gap_ff + 5'h1;
         lb_half_prev_ff <= lb_half;
         if (lb_half != lb_half_prev_ff) begin
            // change seen: set wins over a clearing edge
            lb_skip_ff <= 1'b1;
         end else if (local_bus_clock_out != lb_prev_ff) begin
            lb_skip_ff <= 1'b0;
         end
      end
   end

   property p_ratio_map;
      clk_en && done_ff && pll_ratio_ff == `SCRC_PLL_4TO1 |=> csb_ratio_ff == 3'h4;
   endproperty
   a_ratio_map: assert property (p_ratio_map) else $error("csb ratio wrong");

   property p_lbc_mult;
      clk_en && done_ff |=> lbc_mult_ff == (local_bus_clock_mode_ff ? 2'h2 : 2'h1) &&
         !rsvd_ff == (csb_ratio_ff != 3'h0);
   endproperty
   a_lbc_mult: assert property (p_lbc_mult) else $error("lbc multiple wrong");

   property p_lb_period;
      clk_en && !lb_skip_ff && local_bus_clock_out != lb_prev_ff && lb_prev_ff == 1'b1
         |-> lb_gap_ff == {1'b0, lb_half_prev_ff};
   endproperty
   a_lb_period: assert property (p_lb_period) else $error("local bus clock period wrong");

   property p_mem_ddr;
      clk_en && done_ff ##1 clk_en |-> memory_clock != $past(memory_clock) && mem_beat;
   endproperty
   a_mem_ddr: assert property (p_mem_ddr) else $error("memory beat rate wrong");

   property p_capture;
      $rose(done_ff) |-> pll_ratio_ff == $past(pll_ratio_field) &&
         local_bus_clock_mode_ff == $past(local_bus_clock_mode);
   endproperty
   a_capture: assert property (p_capture) else $error("straps not captured");

   property p_hold;
      done_ff |=> done_ff && $stable(pll_ratio_ff) && $stable(local_bus_clock_mode_ff) && $stable(memcm_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("captured ratios changed");

   property p_bus_answer;
      req && waitreq_ff && clk_en |=> !waitreq_ff;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

   property p_div_write;
      clk_en && take && write && address == `SCRC_OFF_LBCTRL && byteenable[0] &&
         writedata[1:0] == 2'h0
         |=> lbdiv_ff == SCRC_DIV2 ##1 (lb_divisor_ff == 4'h2 || !$past(clk_en));
   endproperty
   a_div_write: assert property (p_div_write) else $error("divider write lost");

   c_capture:  cover property ($rose(done_ff));
   c_reserved: cover property (done_ff && rsvd_ff);
   c_div2:     cover property (clk_en && lb_divisor_ff == 4'h2 && local_bus_clock_mode_ff);

endmodule : scrc_top

// ===== tb/scrc_tb.sv
// self-checking testbench for the clock ratio configuration block
`timescale 1ns/10ps
`include "scrc_consts.svh"
module testbench;
   import scrc_pkg::*;
   // ---------------------------------------------------------------
   // design signals
   // ---------------------------------------------------------------
   logic        clock;                 // 100 MHz bench clock
   logic        rst;                   // power-on reset
   logic        clk_en;                // held high except for a short freeze near the end of the run
   logic [3:0]  pll_ratio_field;       // ratio strap
   logic        local_bus_clock_mode;  // lbc mode strap
   logic        memory_clock_mode;     // memory mode strap
   logic [3:0]  address;               // avalon address
   logic        read;                  // avalon read
   logic        write;                 // avalon write
   logic [31:0] writedata;             // avalon write data
   logic [3:0]  byteenable;            // avalon lanes
   logic [31:0] readdata;              // avalon read data
   logic        waitrequest;           // avalon stall
   logic [2:0]  csb_ratio;             // decoded ratio
   logic [1:0]  lbc_mult;              // lbc multiple
   logic [3:0]  lb_divisor;            // local bus divisor
   logic        cfg_done;              // straps captured
   logic        cfg_reserved;          // reserved code seen
   logic        local_bus_clock_out;   // local bus clock
   logic        memory_clock;          // memory clock
   logic        mem_beat;              // data beat strobe
   int          errors;                // mismatch count
   int          num_checks;            // comparison count
   logic [31:0] rd;                    // last read word
   logic [2:0]  exp_r;                 // expected ratio
   logic [3:0]  dv;                    // expected divisor
   logic        v;                     // previous level of the memory or local bus clock

   scrc_top scrc_top_inst (
      .clock(clock), .rst(rst), .clk_en(clk_en), .pll_ratio_field(pll_ratio_field),
      .local_bus_clock_mode(local_bus_clock_mode), .memory_clock_mode(memory_clock_mode),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .csb_ratio(csb_ratio), .lbc_mult(lbc_mult), .lb_divisor(lb_divisor),
      .cfg_done(cfg_done), .cfg_reserved(cfg_reserved),
      .local_bus_clock_out(local_bus_clock_out), .memory_clock(memory_clock),
      .mem_beat(mem_beat)
   );

   // ---------------------------------------------------------------
   // clock
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // compare and count; case inequality so unknowns never match
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // single exit point of the run
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop

   // avalon write; an edge passes first so strobes never toggle twice in one step
   task bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge clock);
      address <= a; writedata <= d; byteenable <= be; write <= 1'b1;
      n = 0;
      do begin @(posedge clock); n++; end while (waitrequest !== 1'b0 && n < 20);
      write <= 1'b0;
      if (n >= 20) begin errors++; report_and_stop(); end
   endtask : bus_wr

   // avalon read; data taken at the edge that sees waitrequest low
   task bus_rd(input logic [3:0] a, output logic [31:0] d);
      int n;
      @(posedge clock);
      address <= a; read <= 1'b1;
      n = 0;
      do begin @(posedge clock); n++; end while (waitrequest !== 1'b0 && n < 20);
      d = readdata;
      read <= 1'b0;
      if (n >= 20) begin errors++; report_and_stop(); end
   endtask : bus_rd

   // power-on reset with given straps, reset levels checked before release
   task do_reset(input logic [3:0] code, input logic lm, input logic mm);
      @(posedge clock);
      rst <= 1'b1; pll_ratio_field <= code;
      local_bus_clock_mode <= lm; memory_clock_mode <= mm;
      repeat (12) @(posedge clock);
      chk("lb_divisor rst", lb_divisor, 32'h8);
      chk("waitrequest rst", waitrequest, 32'h1);
      chk("cfg_done rst", cfg_done, 32'h0);
      chk("memory_clock rst", memory_clock, 32'h0);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : do_reset

   // half period of the local bus clock; earlier toggles only align the count
   task meas(input int half);
      int n;
      int k;
      n = 0;
      for (k = 0; k < 3; k++) begin
         v = local_bus_clock_out;
         n = 0;
         do begin @(posedge clock); n++; end while (local_bus_clock_out === v && n < 40);
         if (n >= 40) begin errors++; report_and_stop(); end
      end
      chk("lb clock half period", n, half);
   endtask : meas

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      errors = 0; num_checks = 0;
      rst = 1'b1; clk_en = 1'b1; pll_ratio_field = 4'h0;
      local_bus_clock_mode = 1'b0; memory_clock_mode = 1'b0;
      address = 4'h0; read = 1'b0; write = 1'b0; writedata = 32'h0; byteenable = 4'hf;
      // every ratio code, straps scrambled after capture to prove they are held
      for (int c = 0; c < 16; c++) begin
         do_reset(c[3:0], c[0], c[1]);
         exp_r = (c >= 2 && c <= 5) ? c[2:0] : 3'h0;
         chk("csb_ratio", csb_ratio, exp_r);
         chk("cfg_reserved", cfg_reserved, exp_r == 3'h0);
         chk("lbc_mult", lbc_mult, c[0] ? 32'h2 : 32'h1);
         chk("cfg_done", cfg_done, 32'h1);
         @(posedge clock);
         pll_ratio_field <= ~c[3:0];
         local_bus_clock_mode <= ~c[0];
         memory_clock_mode <= ~c[1];
         repeat (3) @(posedge clock);
         bus_rd(`SCRC_OFF_STATUS, rd);
         chk("status", rd, {24'h0, 1'b1, exp_r == 3'h0, c[1], c[0], c[3:0]});
         chk("csb_ratio held", csb_ratio, exp_r);
         chk("lbc_mult held", lbc_mult, c[0] ? 32'h2 : 32'h1);
      end
      // divider codes 0 to 2 in both lbc modes, measured on the output pin
      for (int m = 0; m < 2; m++) begin
         do_reset(`SCRC_PLL_4TO1, m[0], 1'b0);
         for (int d = 0; d < 3; d++) begin
            dv = 4'h2 << d;
            bus_wr(`SCRC_OFF_LBCTRL, d, 4'h1);
            // write lands at the completing edge, the divisor one edge later
            repeat (2) @(posedge clock);
            chk("lb_divisor", lb_divisor, dv);
            bus_rd(`SCRC_OFF_RATIO, rd);
            chk("ratio", rd, {20'h0, dv, 2'h0, m[0] ? 2'h2 : 2'h1, 1'h0, 3'h4});
            meas(m[0] ? dv / 2 : dv);
         end
      end
      // refused writes leave divide-by-8 in place
      bus_wr(`SCRC_OFF_LBCTRL, 32'h3, 4'h1);
      bus_wr(`SCRC_OFF_LBCTRL, 32'h0, 4'h0);
      bus_wr(4'hc, 32'h0, 4'hf);
      bus_wr(`SCRC_OFF_STATUS, 32'h0, 4'hf);
      bus_rd(`SCRC_OFF_LBCTRL, rd);
      chk("lbctrl", rd, 32'h2);
      chk("lb_divisor kept", lb_divisor, 32'h8);
      bus_rd(4'hc, rd);
      chk("unmapped", rd, 32'h0);
      bus_rd(`SCRC_OFF_STATUS, rd);
      chk("status kept", rd, 32'h94);
      // memory clock toggles every cycle with a beat on each edge
      repeat (6) begin
         v = memory_clock;
         @(posedge clock);
         chk("memory_clock", memory_clock, {31'h0, ~v});
         chk("mem_beat", mem_beat, 32'h1);
      end
      // a low enable freezes the memory clock
      clk_en <= 1'b0;
      @(posedge clock);
      v = memory_clock;
      repeat (3) @(posedge clock);
      chk("memory_clock frozen", memory_clock, {31'h0, v});
      clk_en <= 1'b1;
      @(posedge clock);
      report_and_stop();
   end
endmodule : testbench
